// ### shared/cbcr_params.svh
// constants for the can bit clock recovery block
// Function
// RULE1: enable bit makes recovery track the bit stream
// RULE2: host keeps recovery enabled during selective wake
// RULE3: host toggles enable only with transceiver off
// RULE4: host enables only after setup is complete
// RULE5: host setup order: off, clock, quanta, limits, enable
// RULE6: baud change: host updates clock select, quanta
// RULE7: baud or clock change: host rewrites limits
// RULE8: limit reached: discard, reload quanta start value
// RULE9: host disables recovery while changing its registers
// RULE10: sample point register, default 11 0011
// RULE11: bus inactivity after 0.6 to 1.2 s
// RULE12: wake signalled within 100 us
// RULE13: stop mode raises interrupt, sleep raises supply
// RULE14: bit times down to 1 us
// RULE15: quanta per bit depend on clock select
// RULE16: start at quanta value, stay within limits
// RULE17: measure edges of the filtered receive signal
`ifndef CBCR_PARAMS_SVH
`define CBCR_PARAMS_SVH
// register byte addresses
`define CBCR_ADDR_CTRL   8'h00
`define CBCR_ADDR_OSC    8'h04
`define CBCR_ADDR_QUANTA 8'h08
`define CBCR_ADDR_SPOINT 8'h0c
`define CBCR_ADDR_ULIM   8'h10
`define CBCR_ADDR_LLIM   8'h14
`define CBCR_ADDR_STAT   8'h18
`define CBCR_ADDR_ISTAT  8'h1c
`define CBCR_ADDR_IMASK  8'h20
// control and status field positions
`define CBCR_CTRL_EN     0
`define CBCR_CTRL_FILT   2
`define CBCR_CTRL_CAN    4
`define CBCR_CTRL_SBC    8
`define CBCR_STAT_IDLE   8
// interrupt status bits
`define CBCR_IRQ_LIMIT   0
`define CBCR_IRQ_IDLE    1
`define CBCR_IRQ_WAKE    2
// reset values
`define CBCR_QUANTA_RST  8'h64
`define CBCR_ULIM_RST    8'h6e
`define CBCR_LLIM_RST    8'h5a
`define CBCR_SPOINT_RST  6'h33
`define CBCR_OSC_RST     2'h0
`define CBCR_CAN_OFF     3'h0
// timing
`define CBCR_CLK_MHZ        100
`define CBCR_SILENCE_US     600000
`define CBCR_SILENCE_CYCLES (`CBCR_SILENCE_US * `CBCR_CLK_MHZ)
`define CBCR_WAKE_US        100
`define CBCR_WAKE_CYCLES    (`CBCR_WAKE_US * `CBCR_CLK_MHZ)
`define CBCR_BIT_MIN_NS     1000
`endif

// ### shared/cbcr_pkg.sv
// types for the can bit clock recovery block
package cbcr_pkg;
    typedef logic [7:0] cbcr_quanta_t;
    typedef enum logic [1:0] {CBCR_NORMAL, CBCR_STOP, CBCR_SLEEP, CBCR_SPARE} cbcr_sbc_t;
    typedef enum {RC_OFF, RC_TRACK} cbcr_rstate_t;
endpackage

// ### shared/cbcr_rx_if.sv
// filtered receive line between the filter and the recovery core
`timescale 1ns/1ps
`default_nettype none
interface cbcr_rx_if;
    logic       filt;
    logic       edge_p;
    logic [1:0] filt_sel;
    modport src (output filt, output edge_p, input filt_sel);
    modport dst (input filt, input edge_p, output filt_sel);
endinterface
`default_nettype wire

// ### core/cbcr_rx_filter.sv
// glitch filter on the receive line with edge pulse
`timescale 1ns/1ps
`default_nettype none
`include "cbcr_params.svh"
module cbcr_rx_filter (
    // clock and reset
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic ce,
    // raw receive line
    input  wire logic rxd,
    // filtered line
    cbcr_rx_if.src    rx
);
    import cbcr_pkg::*;

    logic [3:0] cnt_reg;
    logic [3:0] cnt_next;
    logic [3:0] need;
    logic       filt_reg;
    logic       filt_next;
    logic       edge_reg;
    logic       edge_next;

    // line must differ for 1, 2, 4 or 8 cycles before it is taken
    always_comb begin
        need      = 4'h1 << rx.filt_sel;
        cnt_next  = cnt_reg;
        filt_next = filt_reg;
        edge_next = 1'b0;
        if (rxd == filt_reg) begin
            cnt_next = 4'h0;
        end else if (cnt_reg + 4'h1 >= need) begin
            filt_next = rxd;  // see RULE17
            cnt_next  = 4'h0;
            edge_next = 1'b1;
        end else begin
            cnt_next = cnt_reg + 4'h1;
        end
    end

    // registers, recessive after reset
    always_ff @(posedge clk) begin
        if (reset) begin
            cnt_reg  <= 4'h0;
            filt_reg <= 1'b1;
            edge_reg <= 1'b0;
        end else if (ce) begin
            cnt_reg  <= cnt_next;
            filt_reg <= filt_next;
            edge_reg <= edge_next;
        end
    end

    assign rx.filt   = filt_reg;
    assign rx.edge_p = edge_reg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // checks on the filter
    a_edge_follows_line: assert property ((edge_reg && $past(ce)) |-> filt_reg == $past(rxd)) // see RULE17
        else $error("filtered edge does not follow line");
    a_glitch_blocked: assert property ((ce && rxd != filt_reg && cnt_reg == 4'h0 && rx.filt_sel == 2'h3)
        |=> !edge_reg) // see RULE17
        else $error("single cycle glitch passed long filter");
endmodule
`default_nettype wire

// ### core/cbcr_top.sv
// bit clock recovery for the selective-wake decoder, apb registers
//
// The register offsets and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "cbcr_params.svh"
module cbcr_top #(
    parameter int unsigned SILENCE_CYCLES = `CBCR_SILENCE_CYCLES
) (
    // clock, reset, enable
    input  wire logic          clk,
    input  wire logic          reset,
    input  wire logic          ce,
    // apb slave
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [7:0]    paddr,
    input  wire logic [31:0]   pwdata,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    // can receive side
    input  wire logic          rxd,
    input  wire logic          wake_event,
    // decoder timing and wake outputs
    output logic               sample_tick,
    output logic               sample_bit,
    output cbcr_pkg::cbcr_quanta_t tracked_quanta,
    output logic               bus_idle,
    output logic               irq,
    output logic               supply_on
);
    import cbcr_pkg::*;

    cbcr_rx_if rx ();

    // register state
    logic [9:0]   ctrl_reg, ctrl_next;
    logic [1:0]   osc_reg, osc_next;
    cbcr_quanta_t quanta_reg, quanta_next;
    logic [5:0]   spoint_reg, spoint_next;
    cbcr_quanta_t ulim_reg, ulim_next;
    cbcr_quanta_t llim_reg, llim_next;
    logic [2:0]   istat_reg, istat_next;
    logic [2:0]   imask_reg, imask_next;
    logic [31:0]  rdata_reg, rdata_next;
    logic         ready_reg, ready_next;
    logic         err_reg, err_next;
    logic         wr_en;
    logic         hit;
    logic [2:0]   w1c;
    logic [2:0]   ev;

    // recovery state
    cbcr_rstate_t rstate_reg, rstate_next;
    logic [1:0]   pre_reg, pre_next;
    cbcr_quanta_t phase_reg, phase_next;
    cbcr_quanta_t trk_reg, trk_next;
    logic         lim_reg, lim_next;
    logic         stick_reg, stick_next;
    logic         sbit_reg, sbit_next;
    logic         q_tick;
    logic [13:0]  sp_prod;
    cbcr_quanta_t sp_pos;

    // idle and wake state
    logic [31:0]  idle_cnt_reg, idle_cnt_next;
    logic         idle_reg, idle_next;
    logic         woken_reg, woken_next;
    logic         irq_reg, irq_next;
    logic         sup_reg, sup_next;
    cbcr_sbc_t    sbc;
    logic         rec_en;

    assign rec_en    = ctrl_reg[`CBCR_CTRL_EN];
    assign sbc       = cbcr_sbc_t'(ctrl_reg[`CBCR_CTRL_SBC +: 2]);
    assign rx.filt_sel = ctrl_reg[`CBCR_CTRL_FILT +: 2];

    cbcr_rx_filter u_filter (
        .clk   (clk),
        .reset (reset),
        .ce    (ce),
        .rxd   (rxd),
        .rx    (rx.src)
    );

    // apb decode, one wait state, read data and error registered
    always_comb begin
        ready_next  = psel && penable && !ready_reg;
        wr_en       = psel && penable && ready_reg && pwrite && !err_reg;
        rdata_next  = rdata_reg;
        err_next    = err_reg;
        hit         = 1'b1;
        w1c         = 3'h0;
        ctrl_next   = ctrl_reg;
        osc_next    = osc_reg;
        quanta_next = quanta_reg;
        spoint_next = spoint_reg;
        ulim_next   = ulim_reg;
        llim_next   = llim_reg;
        imask_next  = imask_reg;
        case (paddr)
            `CBCR_ADDR_CTRL:   rdata_next = {22'h0, ctrl_reg};
            `CBCR_ADDR_OSC:    rdata_next = {30'h0, osc_reg};
            `CBCR_ADDR_QUANTA: rdata_next = {24'h0, quanta_reg};
            `CBCR_ADDR_SPOINT: rdata_next = {26'h0, spoint_reg};
            `CBCR_ADDR_ULIM:   rdata_next = {24'h0, ulim_reg};
            `CBCR_ADDR_LLIM:   rdata_next = {24'h0, llim_reg};
            `CBCR_ADDR_STAT:   rdata_next = {23'h0, idle_reg, trk_reg};
            `CBCR_ADDR_ISTAT:  rdata_next = {29'h0, istat_reg};
            `CBCR_ADDR_IMASK:  rdata_next = {29'h0, imask_reg};
            default: begin
                rdata_next = 32'h0;
                hit        = 1'b0;
            end
        endcase
        if (!ready_next) begin
            rdata_next = rdata_reg;
        end else begin
            err_next = !hit;
        end
        if (wr_en) begin
            case (paddr)
                `CBCR_ADDR_CTRL:   ctrl_next   = pwdata[9:0];
                `CBCR_ADDR_OSC:    osc_next    = pwdata[1:0];   // see RULE15
                `CBCR_ADDR_QUANTA: quanta_next = pwdata[7:0];   // see RULE15
                `CBCR_ADDR_SPOINT: spoint_next = pwdata[5:0];   // see RULE10
                `CBCR_ADDR_ULIM:   ulim_next   = pwdata[7:0];
                `CBCR_ADDR_LLIM:   llim_next   = pwdata[7:0];
                `CBCR_ADDR_ISTAT:  w1c         = pwdata[2:0];
                `CBCR_ADDR_IMASK:  imask_next  = pwdata[2:0];
                default:           w1c         = 3'h0;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            ctrl_reg   <= {2'h0, 1'b0, `CBCR_CAN_OFF, 4'h0};
            osc_reg    <= `CBCR_OSC_RST;
            quanta_reg <= `CBCR_QUANTA_RST;
            spoint_reg <= `CBCR_SPOINT_RST;  // see RULE10
            ulim_reg   <= `CBCR_ULIM_RST;
            llim_reg   <= `CBCR_LLIM_RST;
            imask_reg  <= 3'h0;
            rdata_reg  <= 32'h0;
            ready_reg  <= 1'b0;
            err_reg    <= 1'b0;
        end else if (ce) begin
            ctrl_reg   <= ctrl_next;
            osc_reg    <= osc_next;
            quanta_reg <= quanta_next;
            spoint_reg <= spoint_next;
            ulim_reg   <= ulim_next;
            llim_reg   <= llim_next;
            imask_reg  <= imask_next;
            rdata_reg  <= rdata_next;
            ready_reg  <= ready_next;
            err_reg    <= err_next;
        end
    end

    // quantum prescaler, phase within the bit, tracked bit length
    always_comb begin
        q_tick      = (pre_reg == osc_reg);  // one clock per quantum resolves 1 us bits, see RULE14
        pre_next    = q_tick ? 2'h0 : pre_reg + 2'h1;  // see RULE15
        rstate_next = rstate_reg;
        phase_next  = phase_reg;
        trk_next    = trk_reg;
        lim_next    = 1'b0;
        sp_prod     = trk_reg * spoint_reg;  // see RULE10
        sp_pos      = sp_prod[13:6];
        stick_next  = q_tick && (phase_reg == sp_pos);
        sbit_next   = stick_next ? rx.filt : sbit_reg;
        if (q_tick) begin
            phase_next = (phase_reg + 8'h1 >= trk_reg) ? 8'h0 : phase_reg + 8'h1;
        end
        case (rstate_reg)
            RC_OFF: begin
                trk_next = quanta_reg;  // see RULE1
                if (rec_en) begin
                    rstate_next = RC_TRACK;  // see RULE16
                end
            end
            RC_TRACK: begin
                if (!rec_en) begin
                    rstate_next = RC_OFF;
                    trk_next    = quanta_reg;
                end else if (rx.edge_p && phase_reg != 8'h0) begin
                    // late edge lengthens the bit, early edge shortens it
                    if (phase_reg < (trk_reg >> 1)) begin
                        trk_next = trk_reg + 8'h1;  // see RULE1
                    end else begin
                        trk_next = trk_reg - 8'h1;
                    end
                    if (trk_next >= ulim_reg || trk_next <= llim_reg) begin
                        trk_next = quanta_reg;  // see RULE8
                        lim_next = 1'b1;
                    end
                end
            end
            default: rstate_next = RC_OFF;
        endcase
        if (rx.edge_p) begin
            phase_next = 8'h0;  // see RULE17
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            rstate_reg <= RC_OFF;
            pre_reg    <= 2'h0;
            phase_reg  <= 8'h0;
            trk_reg    <= `CBCR_QUANTA_RST;
            lim_reg    <= 1'b0;
            stick_reg  <= 1'b0;
            sbit_reg   <= 1'b1;
        end else if (ce) begin
            rstate_reg <= rstate_next;
            pre_reg    <= pre_next;
            phase_reg  <= phase_next;
            trk_reg    <= trk_next;
            lim_reg    <= lim_next;
            stick_reg  <= stick_next;
            sbit_reg   <= sbit_next;
        end
    end

    // silence timer, wake handling, sticky status and interrupt
    always_comb begin
        idle_cnt_next = idle_cnt_reg;
        idle_next     = idle_reg;
        if (rx.edge_p) begin
            idle_cnt_next = 32'h0;
            idle_next     = 1'b0;
        end else if (idle_cnt_reg >= SILENCE_CYCLES - 1) begin
            idle_cnt_next = SILENCE_CYCLES;
            idle_next     = 1'b1;  // see RULE11
        end else begin
            idle_cnt_next = idle_cnt_reg + 32'h1;
        end
        ev                  = 3'h0;
        ev[`CBCR_IRQ_LIMIT] = lim_reg;
        ev[`CBCR_IRQ_IDLE]  = idle_next && !idle_reg;
        ev[`CBCR_IRQ_WAKE]  = wake_event;
        istat_next = (istat_reg & ~w1c) | ev;  // set wins over clear
        woken_next = (sbc == CBCR_SLEEP) && (woken_reg || wake_event);  // see RULE13
        sup_next   = (sbc != CBCR_SLEEP) || woken_next;  // see RULE12
        irq_next   = |(istat_next & imask_reg)
                   || (sbc == CBCR_STOP && istat_next[`CBCR_IRQ_WAKE]);  // see RULE13
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            idle_cnt_reg <= 32'h0;
            idle_reg     <= 1'b0;
            istat_reg    <= 3'h0;
            woken_reg    <= 1'b0;
            sup_reg      <= 1'b1;
            irq_reg      <= 1'b0;
        end else if (ce) begin
            idle_cnt_reg <= idle_cnt_next;
            idle_reg     <= idle_next;
            istat_reg    <= istat_next;
            woken_reg    <= woken_next;
            sup_reg      <= sup_next;
            irq_reg      <= irq_next;
        end
    end

    // outputs straight from flip-flops
    assign prdata         = rdata_reg;
    assign pready         = ready_reg;
    assign pslverr        = err_reg;
    assign sample_tick    = stick_reg;
    assign sample_bit     = sbit_reg;
    assign tracked_quanta = trk_reg;
    assign bus_idle       = idle_reg;
    assign irq            = irq_reg;
    assign supply_on      = sup_reg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // checks on recovery, timing and wake
    a_off_holds_start: assert property (rstate_reg == RC_OFF && ce |=> trk_reg == $past(quanta_reg)) // see RULE1
        else $error("tracked length moved while recovery off");
    a_limit_reload: assert property (lim_reg |-> trk_reg == quanta_reg) // see RULE8
        else $error("limit hit without reload of start value");
    a_track_bounds: assert property ((rstate_reg == RC_TRACK && llim_reg < quanta_reg && quanta_reg < ulim_reg
        && $stable(quanta_reg)) |-> trk_reg > llim_reg && trk_reg < ulim_reg) // see RULE16
        else $error("tracked length outside limits");
    a_spoint_default: assert property ($fell(reset) |-> spoint_reg == `CBCR_SPOINT_RST) // see RULE10
        else $error("sample point reset value wrong");
    a_sample_place: assert property ((stick_reg && $past(ce)) |-> $past(phase_reg) == $past(sp_pos)) // see RULE10
        else $error("sample tick off the sample point");
    a_idle_timeout: assert property ($rose(idle_reg) |-> idle_cnt_reg == SILENCE_CYCLES) // see RULE11
        else $error("bus idle raised at wrong count");
    a_wake_stop_irq: assert property ((wake_event && ce && sbc == CBCR_STOP) ##1 ce |-> irq_reg) // see RULE13
        else $error("wake in stop mode did not raise interrupt");
    a_wake_sleep_sup: assert property ((wake_event && ce && sbc == CBCR_SLEEP) |-> ##[1:2] sup_reg) // see RULE12
        else $error("wake in sleep mode did not raise supply");
    c_limit_hit: cover property (lim_reg);
    c_wake_stop: cover property (wake_event && sbc == CBCR_STOP ##1 irq_reg);
    c_bus_idle: cover property ($rose(idle_reg));
endmodule
`default_nettype wire

// ### core/cbcr_placeholder_unused.sv
// intentionally empty of logic: no extra module
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ### bench/cbcr_can_node.sv
// can bus node model driving the raw receive line
`timescale 1ns/1ps
`default_nettype none
module cbcr_can_node (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // traffic control
    input  wire logic        run,
    input  wire logic [15:0] bit_len,
    input  wire logic        pulse_go,
    input  wire logic [7:0]  pulse_len,
    // bus receive line
    output logic             rxd
);
    logic [15:0] cnt_reg;
    logic [7:0]  pcnt_reg;

    // alternating bits of bit_len cycles, bit_len kept at 100 or more
    always_ff @(posedge clk) begin
        if (reset) begin
            rxd      <= 1'b1;
            cnt_reg  <= 16'h0;
            pcnt_reg <= 8'h0;
        end else if (pulse_go) begin
            rxd      <= 1'b0;
            pcnt_reg <= pulse_len;
        end else if (pcnt_reg != 8'h0) begin
            pcnt_reg <= pcnt_reg - 8'h1;
            if (pcnt_reg == 8'h1) begin
                rxd <= 1'b1;
            end
        end else if (run) begin
            if (cnt_reg >= bit_len - 16'h1) begin
                cnt_reg <= 16'h0;
                rxd     <= ~rxd;
            end else begin
                cnt_reg <= cnt_reg + 16'h1;
            end
        end else begin
            cnt_reg <= 16'h0;
            rxd     <= 1'b1; // released bus returns recessive
        end
    end
endmodule
`default_nettype wire

// ### bench/cbcr_top_bench.sv
// self-checking bench for the bit clock recovery block
`timescale 1ns/1ps
`default_nettype none
`include "cbcr_params.svh"
module cbcr_top_bench;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic        ce = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        rxd;
    logic        wake_event = 1'b0;
    logic        sample_tick;
    logic        sample_bit;
    logic [7:0]  tracked_quanta;
    logic        bus_idle;
    logic        irq;
    logic        supply_on;
    logic        run = 1'b0;
    logic [15:0] bit_len = 16'd192;
    logic        pulse_go = 1'b0;
    logic [7:0]  pulse_len = 8'h0;
    logic [31:0] rdata;
    logic        rerr;
    int          n_errors = 0;
    int          compares = 0;
    int          cycles = 0;

    // 100 mhz clock
    initial begin
        forever #5 clk = ~clk;
    end

    // design with a short silence timeout
    cbcr_top #(.SILENCE_CYCLES(200)) dut (.clk(clk), .reset(reset), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rxd(rxd), .wake_event(wake_event),
        .sample_tick(sample_tick), .sample_bit(sample_bit), .tracked_quanta(tracked_quanta),
        .bus_idle(bus_idle), .irq(irq), .supply_on(supply_on));

    // far side bus node
    cbcr_can_node node (.clk(clk), .reset(reset), .run(run), .bit_len(bit_len),
        .pulse_go(pulse_go), .pulse_len(pulse_len), .rxd(rxd));

    task automatic tally_and_finish;
        if (n_errors == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            n_errors++;
            tally_and_finish();
        end
    end

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic check_flag(input logic got, input logic exp);
        check_word({31'h0, got}, {31'h0, exp});
    endtask

    // one apb transfer, result left in rdata and rerr
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // wait on rising edges until pready; the loop has no limit, a stall is ended only by the hang guard
        @(posedge clk);
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic pulse(input logic [7:0] len);
        @(posedge clk);
        pulse_len <= len;
        pulse_go <= 1'b1;
        @(posedge clk);
        pulse_go <= 1'b0;
    endtask

    // wake pulse, then wait for irq (stop) or supply (sleep)
    task automatic wake_and_wait(input logic sleep);
        int n;
        n = 0;
        @(posedge clk);
        wake_event <= 1'b1;
        @(posedge clk);
        wake_event <= 1'b0;
        @(negedge clk);
        while ((sleep ? supply_on : irq) !== 1'b1 && n < `CBCR_WAKE_CYCLES) begin
            @(negedge clk);
            n++;
        end
        check_flag(sleep ? supply_on : irq, 1'b1); // wake reported in time
    endtask

    task automatic t_reset;
        logic [7:0]  addrs [10];
        logic [31:0] exps [10];
        addrs = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h18};
        exps = '{32'h0, 32'h0, 32'h64, 32'h33, 32'h6e, 32'h5a, 32'h64, 32'h0, 32'h0, 32'h64};
        @(negedge clk);
        check_word({24'h0, tracked_quanta}, 32'h64); // start value
        check_flag(supply_on, 1'b1); // supply on out of reset
        check_flag(irq, 1'b0); // no wake yet
        for (int i = 0; i < 10; i++) begin
            if (i == 9) begin
                apb(1'b1, `CBCR_ADDR_STAT, 32'hff);
            end
            apb(1'b0, addrs[i], 32'h0);
            check_word(rdata, exps[i]); // defaults incl. sample point
        end
        apb(1'b0, 8'h24, 32'h0);
        check_flag(rerr, 1'b1);
        check_word(rdata, 32'h0);
    endtask

    task automatic t_disabled;
        apb(1'b1, `CBCR_ADDR_CTRL, 32'h0); // mode off
        apb(1'b1, `CBCR_ADDR_OSC, 32'h1); // baud change
        apb(1'b1, `CBCR_ADDR_QUANTA, 32'h50); // baud change
        @(posedge clk);
        run <= 1'b1;
        settle(2000);
        check_word({24'h0, tracked_quanta}, 32'h50); // no tracking when off
        apb(1'b1, `CBCR_ADDR_QUANTA, 32'h64);
        settle(3);
        check_word({24'h0, tracked_quanta}, 32'h64); // follows quanta
    endtask

    task automatic t_track;
        int ticks;
        int bad;
        ticks = 0;
        bad = 0;
        apb(1'b1, `CBCR_ADDR_CTRL, 32'h0); // off while changing
        apb(1'b1, `CBCR_ADDR_OSC, 32'h0); // one clock per quantum
        apb(1'b1, `CBCR_ADDR_QUANTA, 32'h68); // start away from line rate
        @(posedge clk);
        bit_len <= 16'd100;
        apb(1'b1, `CBCR_ADDR_CTRL, 32'h1); // enable after setup
        settle(2000);
        check_flag(tracked_quanta >= 8'd99 && tracked_quanta <= 8'd101, 1'b1); // 1 us bits
        @(posedge clk);
        bit_len <= 16'd192;
        apb(1'b1, `CBCR_ADDR_CTRL, 32'h0); // off first
        apb(1'b1, `CBCR_ADDR_OSC, 32'h1); // clock select
        apb(1'b1, `CBCR_ADDR_QUANTA, 32'h64); // quanta
        apb(1'b1, `CBCR_ADDR_ULIM, 32'h6e); // limits
        apb(1'b1, `CBCR_ADDR_LLIM, 32'h5a); // limits
        apb(1'b1, `CBCR_ADDR_CTRL, 32'h1); // enable last
        settle(6000);
        check_flag(tracked_quanta >= 8'd95 && tracked_quanta <= 8'd97, 1'b1); // tracks 96
        // ten bits: one sample each, taken well inside the bit
        repeat (1920) begin
            @(negedge clk);
            if (sample_tick) begin
                ticks++;
                if (sample_bit !== rxd) begin
                    bad++;
                end
            end
        end
        check_flag(ticks >= 9 && ticks <= 11, 1'b1); // one sample per bit
        check_word(bad, 32'h0); // sampled value matches the bit
    endtask

    task automatic t_limit;
        int viol;
        viol = 0;
        apb(1'b1, `CBCR_ADDR_CTRL, 32'h0); // disable while changing
        apb(1'b1, `CBCR_ADDR_ULIM, 32'h66);
        apb(1'b1, `CBCR_ADDR_LLIM, 32'h62);
        apb(1'b1, `CBCR_ADDR_IMASK, 32'h1);
        apb(1'b1, `CBCR_ADDR_CTRL, 32'h1); // enable after setup
        repeat (4000) begin
            @(negedge clk);
            if (!(tracked_quanta > 8'h62 && tracked_quanta < 8'h66)) begin
                viol++;
            end
        end
        check_word(viol, 32'h0); // kept inside limits
        check_flag(irq, 1'b1); // limit reload flagged
        @(posedge clk);
        run <= 1'b0;
        apb(1'b1, `CBCR_ADDR_IMASK, 32'h0);
        settle(2);
        check_flag(irq, 1'b0);
        apb(1'b0, `CBCR_ADDR_ISTAT, 32'h0);
        check_flag(rdata[0], 1'b1); // sticky limit bit
        apb(1'b1, `CBCR_ADDR_ISTAT, 32'h1);
        apb(1'b0, `CBCR_ADDR_ISTAT, 32'h0);
        check_flag(rdata[0], 1'b0);
    endtask

    task automatic t_idle;
        apb(1'b1, `CBCR_ADDR_CTRL, 32'hc);
        pulse(8'd30);
        settle(218);
        check_flag(bus_idle, 1'b0); // not before timeout
        settle(50);
        check_flag(bus_idle, 1'b1); // idle after timeout
        apb(1'b0, `CBCR_ADDR_ISTAT, 32'h0);
        check_flag(rdata[1], 1'b1);
        pulse(8'd3);
        settle(40);
        check_flag(bus_idle, 1'b1); // glitch filtered out
        pulse(8'd30);
        settle(25);
        check_flag(bus_idle, 1'b0); // filtered edge seen
        // clock enable low freezes the silence timer
        @(posedge clk);
        ce <= 1'b0;
        settle(300);
        check_flag(bus_idle, 1'b0); // timer frozen
        @(posedge clk);
        ce <= 1'b1;
        settle(250);
        check_flag(bus_idle, 1'b1); // timer resumes
    endtask

    task automatic t_wake;
        apb(1'b1, `CBCR_ADDR_ISTAT, 32'h7);
        apb(1'b1, `CBCR_ADDR_CTRL, 32'h100);
        wake_and_wait(1'b0); // stop mode raises irq
        apb(1'b1, `CBCR_ADDR_ISTAT, 32'h4);
        settle(2);
        check_flag(irq, 1'b0);
        apb(1'b1, `CBCR_ADDR_CTRL, 32'h200);
        settle(2);
        check_flag(supply_on, 1'b0);
        wake_and_wait(1'b1); // sleep mode raises supply
        apb(1'b1, `CBCR_ADDR_CTRL, 32'h0);
    endtask

    // main sequence
    initial begin
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        t_reset();
        t_disabled();
        t_track();
        t_limit();
        t_idle();
        t_wake();
        tally_and_finish();
    end
endmodule
`default_nettype wire
